// *** rtl/ivc_pkg.sv ***
package ivc_pkg;
	// Vector count, source count and pins that arrive from outside the clock domain
	localparam int NUM_VEC = 10;
	localparam int NUM_SRC = 21;
	localparam int NUM_PIN = 7;
	// Vectors below this index may take the top level instead of high
	localparam int TOP_CAPABLE = 2;
	localparam int IDX_W = 4;
	localparam int ADDR_W = 16;
	// Vector address map: first entry and spacing
	localparam logic [ADDR_W-1:0] VEC_BASE = 16'h0003;
	localparam logic [ADDR_W-1:0] VEC_STEP = 16'h0008;
	localparam logic [ADDR_W-1:0] VEC_LAST = 16'h004B;

	// Source bit positions within the gathered source word
	// 0 ext a | 1 ext b | 2 ext c | 3 timer0 low | 4 ext e | 5 ext d | 6 ext f
	// 7 base timer | 8 timer0 high | 9 timer1 low | 10 timer1 high | 11 sync serial
	// 12 duplex rx | 13 async serial | 14 duplex tx | 15 converter | 16 timer6
	// 17 timer7 | 18 pwm a | 19 pwm b | 20 port 0
	typedef logic [NUM_SRC-1:0] ivc_src_mask_t;
	localparam ivc_src_mask_t VEC_SRC_MASK [NUM_VEC] = '{
		21'h000001, 21'h000002, 21'h00001C, 21'h0000E0, 21'h000100,
		21'h000600, 21'h001800, 21'h006000, 21'h0F8000, 21'h100000
	};

	// Priority levels in ascending order; none means nothing in service
	typedef enum logic [1:0] {LVL_NONE, LVL_LOW, LVL_HIGH, LVL_TOP} ivc_level_t;
endpackage : ivc_pkg

// *** rtl/ivc_ctrl.sv ***
`timescale 1ns/1ps
module ivc_ctrl (
	input wire logic clk,
	input wire logic reset,
	input wire logic ext_irq_a,
	input wire logic ext_irq_b,
	input wire logic ext_irq_c,
	input wire logic ext_irq_d,
	input wire logic ext_irq_e,
	input wire logic ext_irq_f,
	input wire logic port0_irq,
	input wire logic timer_zero_low_evt,
	input wire logic timer_zero_high_evt,
	input wire logic timer_one_low_evt,
	input wire logic timer_one_high_evt,
	input wire logic base_timer_evt,
	input wire logic sync_serial_evt,
	input wire logic async_serial_evt,
	input wire logic duplex_rx_evt,
	input wire logic duplex_tx_evt,
	input wire logic converter_evt,
	input wire logic timer_six_evt,
	input wire logic timer_seven_evt,
	input wire logic pwm_chan_a_evt,
	input wire logic pwm_chan_b_evt,
	input wire logic [ivc_pkg::NUM_SRC-1:0] src_enable,
	input wire logic [ivc_pkg::NUM_VEC-1:0] vec_level_upper,
	input wire logic irq_ack,
	input wire logic irq_return,
	output logic irq_req,
	output logic [ivc_pkg::ADDR_W-1:0] irq_vector,
	output logic [ivc_pkg::IDX_W-1:0] irq_index,
	output ivc_pkg::ivc_level_t irq_level,
	output ivc_pkg::ivc_level_t service_level
);
	import ivc_pkg::*;

	logic [NUM_PIN-1:0] pin_raw;
	logic [NUM_PIN-1:0] sync1_reg;
	logic [NUM_PIN-1:0] sync1_next;
	logic [NUM_PIN-1:0] sync2_reg;
	logic [NUM_PIN-1:0] sync2_next;
	logic [NUM_SRC-1:0] src_pend;
	logic [NUM_VEC-1:0] vec_pend;
	ivc_level_t vec_lvl [NUM_VEC];
	ivc_level_t cur_level;
	ivc_level_t best_lvl;
	logic [IDX_W-1:0] best_idx;
	logic found;
	logic req_reg;
	logic req_next;
	logic [ADDR_W-1:0] vec_reg;
	logic [ADDR_W-1:0] vec_next;
	logic [IDX_W-1:0] idx_reg;
	logic [IDX_W-1:0] idx_next;
	ivc_level_t lvl_reg;
	ivc_level_t lvl_next;
	logic [2:0] svc_reg;
	logic [2:0] svc_next;
	logic take;

	// Pins are asynchronous; two flops before anything looks at them
	assign pin_raw = {port0_irq, ext_irq_f, ext_irq_d, ext_irq_e, ext_irq_c, ext_irq_b, ext_irq_a};

	always_comb begin
		sync1_next = pin_raw;
		sync2_next = sync1_reg;
	end

	// Synchroniser stages; only the second stage feeds the sources
	always_ff @(posedge clk) begin
		if (reset) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= sync1_next;
			sync2_reg <= sync2_next;
		end
	end

	// Gather sources in the package bit order
	assign src_pend = {sync2_reg[6], pwm_chan_b_evt, pwm_chan_a_evt, timer_seven_evt,
		timer_six_evt, converter_evt, duplex_tx_evt, async_serial_evt, duplex_rx_evt,
		sync_serial_evt, timer_one_high_evt, timer_one_low_evt, timer_zero_high_evt,
		base_timer_evt, sync2_reg[5], sync2_reg[4], sync2_reg[3], timer_zero_low_evt,
		sync2_reg[2], sync2_reg[1], sync2_reg[0]};

	// Per-vector request and level; flags stay in the peripherals for software
	for (genvar v = 0; v < NUM_VEC; v++) begin : g_vec
		assign vec_pend[v] = |(src_pend & src_enable & VEC_SRC_MASK[v]);
		assign vec_lvl[v] = !vec_level_upper[v] ? LVL_LOW : (v < TOP_CAPABLE) ? LVL_TOP : LVL_HIGH;
	end

	always_comb begin
		if (svc_reg[2]) begin
			cur_level = LVL_TOP;
		end else if (svc_reg[1]) begin
			cur_level = LVL_HIGH;
		end else if (svc_reg[0]) begin
			cur_level = LVL_LOW;
		end else begin
			cur_level = LVL_NONE;
		end
	end

	// Descending scan with >= lets the smallest index win a tie
	always_comb begin
		best_lvl = LVL_NONE;
		best_idx = '0;
		found = 1'b0;
		for (int v = NUM_VEC - 1; v >= 0; v--) begin
			if (vec_pend[v] && vec_lvl[v] > cur_level && vec_lvl[v] >= best_lvl) begin
				best_lvl = vec_lvl[v];
				best_idx = IDX_W'(v);
				found = 1'b1;
			end
		end
	end

	// Request, vector and nesting state; return unwinds before a new accept
	assign take = irq_ack && req_reg;

	always_comb begin
		svc_next = svc_reg;
		if (irq_return) begin
			if (svc_reg[2]) begin
				svc_next[2] = 1'b0;
			end else if (svc_reg[1]) begin
				svc_next[1] = 1'b0;
			end else begin
				svc_next[0] = 1'b0;
			end
		end
		if (take) begin
			unique case (lvl_reg)
				LVL_TOP: svc_next[2] = 1'b1;
				LVL_HIGH: svc_next[1] = 1'b1;
				LVL_LOW: svc_next[0] = 1'b1;
				LVL_NONE: svc_next = svc_next;
			endcase
		end
		// One idle cycle after an accept so the new level is seen first
		req_next = take ? 1'b0 : found;
		vec_next = vec_reg;
		idx_next = idx_reg;
		lvl_next = lvl_reg;
		if (found && !take) begin
			vec_next = ADDR_W'(VEC_BASE + VEC_STEP * ADDR_W'(best_idx));
			idx_next = best_idx;
			lvl_next = best_lvl;
		end
	end

	// Request and nesting registers
	always_ff @(posedge clk) begin
		if (reset) begin
			req_reg <= 1'b0;
			vec_reg <= VEC_BASE;
			idx_reg <= '0;
			lvl_reg <= LVL_NONE;
			svc_reg <= '0;
		end else begin
			req_reg <= req_next;
			vec_reg <= vec_next;
			idx_reg <= idx_next;
			lvl_reg <= lvl_next;
			svc_reg <= svc_next;
		end
	end

	// Offer straight from the registers; service level decoded from nesting bits
	assign irq_req = req_reg;
	assign irq_vector = vec_reg;
	assign irq_index = idx_reg;
	assign irq_level = lvl_reg;
	assign service_level = cur_level;

	// Independent reference arbiter, used only by the checks below
	ivc_level_t chk_max;
	logic [IDX_W-1:0] chk_first;
	always_comb begin
		chk_max = LVL_NONE;
		chk_first = '0;
		for (int v = 0; v < NUM_VEC; v++) begin
			if (vec_pend[v] && vec_lvl[v] > cur_level && vec_lvl[v] > chk_max) begin
				chk_max = vec_lvl[v];
			end
		end
		for (int v = NUM_VEC - 1; v >= 0; v--) begin
			if (vec_pend[v] && vec_lvl[v] == chk_max && chk_max != LVL_NONE) begin
				chk_first = IDX_W'(v);
			end
		end
	end

	// Checks against the reference arbiter and the nesting state
	a_level_valid: assert property (@(posedge clk) disable iff (reset)
		irq_req |-> irq_level inside {LVL_LOW, LVL_HIGH, LVL_TOP})
		else $error("request carries no level");
	a_above_service: assert property (@(posedge clk) disable iff (reset)
		irq_req |-> irq_level > service_level)
		else $error("request not above in-service level");
	a_highest_first: assert property (@(posedge clk) disable iff (reset)
		(found && !take) |=> irq_req && irq_level == $past(chk_max))
		else $error("not the highest pending level");
	a_smallest_vector: assert property (@(posedge clk) disable iff (reset)
		(found && !take) |=> irq_index == $past(chk_first))
		else $error("tie not broken by smallest vector");
	a_vector_map: assert property (@(posedge clk) disable iff (reset)
		irq_req |-> irq_vector == VEC_BASE + VEC_STEP * irq_index && irq_vector <= VEC_LAST)
		else $error("vector address off the map");
	a_top_restricted: assert property (@(posedge clk) disable iff (reset)
		(irq_req && irq_level == LVL_TOP) |-> irq_index < TOP_CAPABLE)
		else $error("top level on a vector that cannot take it");
	a_shared_request: assert property (@(posedge clk) disable iff (reset)
		(vec_pend != '0 && service_level == LVL_NONE && !take) |=> irq_req)
		else $error("pending enabled source raised no request");
	a_accept_nests: assert property (@(posedge clk) disable iff (reset)
		(take && !irq_return) |=> !irq_req ##1 service_level == $past(irq_level, 2))
		else $error("accept did not raise the service level");

	// Main scenarios: top grant, two-deep nesting, unwinding
	c_top_grant: cover property (@(posedge clk) disable iff (reset)
		take && irq_level == LVL_TOP);
	c_nested: cover property (@(posedge clk) disable iff (reset)
		svc_reg[0] && svc_reg[1]);
	c_unwind: cover property (@(posedge clk) disable iff (reset)
		irq_return && service_level == LVL_HIGH);
endmodule : ivc_ctrl

// *** dv/ivc_cpu_model.sv ***
`timescale 1ns/1ps
module ivc_cpu_model (
	input wire logic clk,
	input wire logic reset,
	input wire logic irq_req,
	input wire logic take,
	input wire logic ret,
	output logic irq_ack,
	output logic irq_return
);
	// Core takes an offered vector only when told, one pulse each
	always_ff @(negedge clk) begin
		irq_ack <= !reset && take && irq_req && !irq_ack;
		irq_return <= !reset && ret && !irq_return;
	end
endmodule : ivc_cpu_model

// *** dv/tb_ivc_ctrl.sv ***
`timescale 1ns/1ps
module tb_ivc_ctrl;
	import ivc_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic take = 1'b0;
	logic ret = 1'b0;
	ivc_src_mask_t src = '0;
	ivc_src_mask_t en = '1;
	logic [NUM_VEC-1:0] up = '0;
	logic irq_ack, irq_return, irq_req;
	logic [ADDR_W-1:0] irq_vector;
	logic [IDX_W-1:0] irq_index;
	ivc_level_t irq_level, service_level;
	int mismatches = 0;
	int check_count = 0;

	// Free running 100 MHz clock
	initial begin
		forever #5 clk = ~clk;
	end

	ivc_ctrl dut_u (.clk(clk), .reset(reset), .ext_irq_a(src[0]), .ext_irq_b(src[1]),
		.ext_irq_c(src[2]), .timer_zero_low_evt(src[3]), .ext_irq_e(src[4]), .ext_irq_d(src[5]),
		.ext_irq_f(src[6]), .base_timer_evt(src[7]), .timer_zero_high_evt(src[8]),
		.timer_one_low_evt(src[9]), .timer_one_high_evt(src[10]), .sync_serial_evt(src[11]),
		.duplex_rx_evt(src[12]), .async_serial_evt(src[13]), .duplex_tx_evt(src[14]),
		.converter_evt(src[15]), .timer_six_evt(src[16]), .timer_seven_evt(src[17]),
		.pwm_chan_a_evt(src[18]), .pwm_chan_b_evt(src[19]), .port0_irq(src[20]),
		.src_enable(en), .vec_level_upper(up), .irq_ack(irq_ack), .irq_return(irq_return),
		.irq_req(irq_req), .irq_vector(irq_vector), .irq_index(irq_index),
		.irq_level(irq_level), .service_level(service_level));

	ivc_cpu_model cpu_u (.clk(clk), .reset(reset), .irq_req(irq_req), .take(take), .ret(ret),
		.irq_ack(irq_ack), .irq_return(irq_return));

	task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_val

	task automatic chk_lvl(input string what, input ivc_level_t exp, input ivc_level_t got);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %0d seen %0d", what, exp, got);
		end
	endtask : chk_lvl

	// Five cycles cover the two pin synchroniser stages
	task automatic drive(input ivc_src_mask_t s, input logic [NUM_VEC-1:0] u);
		@(negedge clk);
		src <= s;
		up <= u;
		repeat (5) @(negedge clk);
	endtask : drive

	task automatic offer(input logic [15:0] idx, input ivc_level_t lvl);
		chk_val("irq_req", 16'h0001, {15'h0000, irq_req});
		chk_val("irq_index", idx, {12'h000, irq_index});
		chk_val("irq_vector", 16'h0003 + 16'h0008 * idx, irq_vector);
		chk_lvl("irq_level", lvl, irq_level);
	endtask : offer

	// Held two falling edges; the core model makes one pulse of it
	task automatic cpu(input bit do_ret);
		@(negedge clk);
		take <= !do_ret;
		ret <= do_ret;
		repeat (2) @(negedge clk);
		take <= 1'b0;
		ret <= 1'b0;
		repeat (3) @(negedge clk);
	endtask : cpu

	task automatic t_map;
		ivc_src_mask_t s;
		chk_lvl("service_level", LVL_NONE, service_level);
		for (int v = 0; v < NUM_VEC; v++) begin
			s = VEC_SRC_MASK[v] & ~(VEC_SRC_MASK[v] - 21'h000001);
			drive(s, '0);
			offer(v[15:0], LVL_LOW);
			drive('0, '0);
			chk_val("irq_req", 16'h0000, {15'h0000, irq_req});
		end
		$display("t_map done");
	endtask : t_map

	task automatic t_shared;
		en <= 21'h020000;
		drive(21'h010000, '0);
		chk_val("irq_req", 16'h0000, {15'h0000, irq_req});
		drive(21'h030000, '0);
		offer(16'h0008, LVL_LOW);
		en <= '1;
		drive('0, '0);
		$display("t_shared done");
	endtask : t_shared

	task automatic t_prio;
		drive(21'h000280, 10'h020);
		offer(16'h0005, LVL_HIGH);
		drive(21'h000280, 10'h000);
		offer(16'h0003, LVL_LOW);
		drive(21'h000282, 10'h022);
		offer(16'h0001, LVL_TOP);
		drive('0, '0);
		$display("t_prio done");
	endtask : t_prio

	task automatic t_nest;
		drive(21'h000280, 10'h020);
		cpu(1'b0);
		chk_lvl("service_level", LVL_HIGH, service_level);
		chk_val("irq_req", 16'h0000, {15'h0000, irq_req});
		drive(21'h000281, 10'h021);
		offer(16'h0000, LVL_TOP);
		cpu(1'b0);
		chk_lvl("service_level", LVL_TOP, service_level);
		cpu(1'b1);
		chk_lvl("service_level", LVL_HIGH, service_level);
		offer(16'h0000, LVL_TOP);
		drive(21'h000080, 10'h000);
		chk_val("irq_req", 16'h0000, {15'h0000, irq_req});
		cpu(1'b1);
		chk_lvl("service_level", LVL_NONE, service_level);
		offer(16'h0003, LVL_LOW);
		// Low accept, then high nests on top of it and both unwind
		cpu(1'b0);
		chk_lvl("service_level", LVL_LOW, service_level);
		chk_val("irq_req", 16'h0000, {15'h0000, irq_req});
		drive(21'h000280, 10'h020);
		offer(16'h0005, LVL_HIGH);
		cpu(1'b0);
		chk_lvl("service_level", LVL_HIGH, service_level);
		cpu(1'b1);
		chk_lvl("service_level", LVL_LOW, service_level);
		cpu(1'b1);
		chk_lvl("service_level", LVL_NONE, service_level);
		drive('0, '0);
		$display("t_nest done");
	endtask : t_nest

	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : final_report

	// Main sequence after four reset cycles
	initial begin
		repeat (4) @(negedge clk);
		reset <= 1'b0;
		t_map;
		t_shared;
		t_prio;
		t_nest;
		final_report;
	end

	// Watchdog well beyond the few hundred cycles the tests need
	initial begin
		#20000;
		mismatches++;
		final_report;
	end
endmodule : tb_ivc_ctrl
